/* tsi_pkg.sv */
// constants for the switch host access and transmit connection logic
// assumes one 200 MHz system clock shared by every user of the package
`default_nettype none
package tsi_pkg;
  // host register offsets (address bit 7 low)
  localparam logic [6:0] TSI_OFS_PAGE_SELECT   = 7'h00;
  localparam logic [6:0] TSI_OFS_PHASE_LOW     = 7'h08;
  localparam logic [6:0] TSI_OFS_PHASE_HIGH    = 7'h09;
  localparam int         TSI_ADDR_MEM_BIT      = 7;
  // page select register fields
  localparam int         TSI_SEL_PATH_BIT      = 7;
  localparam int         TSI_SEL_LO            = 5;
  localparam int         TSI_PAGE_W            = 5;
  localparam logic [7:0] TSI_PAGE_SELECT_RST   = 8'h00;
  // memory select sub codes
  localparam logic [1:0] TSI_MS_CM_LOW         = 2'h0;
  localparam logic [1:0] TSI_MS_CM_HIGH        = 2'h1;
  localparam logic [1:0] TSI_MS_DATA           = 2'h2;
  localparam logic [1:0] TSI_MS_BLOCK          = 2'h3;
  // tx connection memory high fields
  localparam int         TSI_CMH_OE            = 0;
  localparam int         TSI_CMH_BYPASS        = 1;
  localparam int         TSI_CMH_MSG           = 2;
  localparam int         TSI_CMH_CTL1          = 3;
  localparam int         TSI_CMH_SRC_LO        = 4;
  localparam int         TSI_SRC_W             = 4;
  // phase status word
  localparam int         TSI_PSW_W             = 11;
  localparam int         TSI_PSW_TOGGLE        = 10;
  localparam logic [2:0] TSI_PSW_HIGH_PAD      = 3'h0;
  // memory depths and channel counts
  localparam int         TSI_PAR_DEPTH         = 2430;
  localparam int         TSI_SER_DEPTH         = 512;
  localparam logic [11:0] TSI_CH_1944          = 12'h097E;
  localparam logic [11:0] TSI_CH_16384         = 12'h0800;
  localparam logic [11:0] TSI_CH_648           = 12'h032A;
  // phase clock: 4.096 MHz, half periods generated by an accumulator
  localparam int         TSI_SYS_KHZ           = 200000;
  localparam int         TSI_PH_KHZ            = 4096;
  localparam logic [17:0] TSI_ACC_STEP         = 18'(2 * TSI_PH_KHZ);
  localparam logic [17:0] TSI_ACC_WRAP         = 18'(TSI_SYS_KHZ);
  localparam logic [1:0] TSI_FRAMES_PER_SAMPLE = 2'h2;

  typedef enum logic [1:0] {TSI_TM1, TSI_TM2, TSI_TM3, TSI_TM4} tsi_tmode_t;
  typedef enum logic [1:0] {TSI_SER_2M_BAL, TSI_SER_2M_ADD, TSI_SER_4M,
                            TSI_SER_8M} tsi_ser_rate_t;
  typedef enum logic [1:0] {TSI_PAR_1944, TSI_PAR_16384, TSI_PAR_648,
                            TSI_PAR_RSVD} tsi_par_rate_t;
  typedef enum logic {TSI_BP_IDLE, TSI_BP_RUN} tsi_bp_state_t;
endpackage : tsi_pkg
`default_nettype wire

/* tsi_mem_access.sv */
// host page access, phase status capture and transmit connection output
// assumes host pins asynchronous to clk_sys; mode inputs on clk_sys
// Function
// - page register steers address bit 7 high accesses
// - address bit 7 low reaches control registers
// - select bits pick cm low, high, data, block
// - memory address is page bits plus lines 6-0
// - 2M balanced: 8 streams, 32 slots, 256 channels
// - 2M add/drop: 16 streams, 32 slots
// - 4M: 8 streams of 64 slots
// - 8M: 4 streams of 128 slots
// - tx cm page bits by parallel channel count
// - parallel source uses 12, 11, 10 bits
// - capture phase word every second frame pulse
// - phase bit, cycle count, frame toggle bit
// - phase bytes at addresses 8 and 9
// - output enable bit drives tristate and ctl0
// - bypass from receive port in modes 1, 2
// - message bit outputs low byte else addresses
// - control pins 1-3; 2, 3 off in mode 4
// - source width depends on timing mode four
// - tx cm high and low 2430 bytes each
// - message pattern repeats every frame until changed
// - block programming loads top four, zeroes rest
`default_nettype none
module tsi_mem_access
  import tsi_pkg::*;
#(
  parameter int PAR_DEPTH = TSI_PAR_DEPTH,
  parameter int SER_DEPTH = TSI_SER_DEPTH
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic       host_cs_n,
  input  wire logic       host_ale,
  input  wire logic       host_rd_n,
  input  wire logic       host_wr_n,
  input  wire logic [7:0] host_ad_in,
  output logic      [7:0] host_ad_out,
  output logic            host_ad_oe,
  input  wire logic [1:0] timing_mode,
  input  wire logic [1:0] serial_rate,
  input  wire logic [1:0] parallel_rate,
  input  wire logic       block_prog_enable,
  input  wire logic [3:0] block_prog_data,
  output logic            block_prog_busy,
  input  wire logic       rx_parallel_frame_pulse,
  input  wire logic [7:0] rx_parallel_lines,
  input  wire logic       ser_in_valid,
  input  wire logic [8:0] ser_in_chan,
  input  wire logic [7:0] ser_in_data,
  output logic      [7:0] parallel_output_lines,
  output logic            parallel_output_oe,
  output logic            output_enable_ctl0,
  output logic      [2:0] ext_control_pins
);
  localparam int PW = $clog2(PAR_DEPTH);
  localparam int SW = $clog2(SER_DEPTH);

  // memories
  logic [7:0] tx_cm_low  [PAR_DEPTH];
  logic [7:0] tx_cm_high [PAR_DEPTH];
  logic [7:0] tx_data_mem[SER_DEPTH];
  logic [7:0] rx_cm_low  [SER_DEPTH];
  logic [6:0] rx_cm_high [SER_DEPTH];
  logic [7:0] rx_data_mem[PAR_DEPTH];

  // channels per frame at each parallel rate
  function automatic logic [11:0] par_chans(input tsi_par_rate_t r);
    unique case (r)
      TSI_PAR_16384: par_chans = TSI_CH_16384;
      TSI_PAR_648:   par_chans = TSI_CH_648;
      default:       par_chans = TSI_CH_1944;
    endcase
  endfunction : par_chans

  // serial channel index kept inside the stream/slot space of the rate
  function automatic logic [8:0] ser_mask(input tsi_ser_rate_t r,
                                          input logic [11:0] a);
    unique case (r)
      TSI_SER_2M_BAL: ser_mask = {1'b0, a[7:0]};
      TSI_SER_2M_ADD: ser_mask = a[8:0];
      TSI_SER_4M:     ser_mask = a[8:0];
      TSI_SER_8M:     ser_mask = a[8:0];
    endcase
  endfunction : ser_mask

  // parallel source index trimmed to the bit width of the channel count of the rate
  function automatic logic [11:0] par_mask(input tsi_par_rate_t r,
                                           input logic [11:0] a);
    unique case (r)
      TSI_PAR_16384: par_mask = {1'b0, a[10:0]};
      TSI_PAR_648:   par_mask = {2'b00, a[9:0]};
      default:       par_mask = a;
    endcase
  endfunction : par_mask

  tsi_tmode_t    tmode;
  tsi_ser_rate_t srate;
  tsi_par_rate_t prate;
  assign tmode = tsi_tmode_t'(timing_mode);
  assign srate = tsi_ser_rate_t'(serial_rate);
  assign prate = tsi_par_rate_t'(parallel_rate);

  // two-stage synchronisers on every host and frame pin
  logic [12:0] pin_s1;
  logic [12:0] pin_s2;
  logic [7:0]  rx_par_s1;
  logic [7:0]  rx_par;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      // strobes idle high, latch enable idle low: no false latch
      pin_s1    <= 13'h1_C00;
      pin_s2    <= 13'h1_C00;
      rx_par_s1 <= 8'h00;
      rx_par    <= 8'h00;
    end else if (clk_en) begin
      pin_s1    <= {host_cs_n, host_rd_n, host_wr_n, host_ale,
                    rx_parallel_frame_pulse, host_ad_in};
      pin_s2    <= pin_s1;
      rx_par_s1 <= rx_parallel_lines;
      rx_par    <= rx_par_s1;
    end
  end

  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic       ale;
  logic       fp;
  logic [7:0] ad;
  assign {cs_n, rd_n, wr_n, ale, fp, ad} = pin_s2;

  logic       wr_n_d;
  logic       fp_d;
  logic [7:0] addr_lat;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_n_d   <= 1'b1;
      fp_d     <= 1'b0;
      addr_lat <= 8'h00;
    end else if (clk_en) begin
      wr_n_d <= wr_n;
      fp_d   <= fp;
      if (ale) begin
        addr_lat <= ad;
      end
    end
  end

  logic host_wr;
  logic host_rd;
  logic frame_start;
  assign host_wr     = !cs_n && !wr_n && wr_n_d;
  assign host_rd     = !cs_n && !rd_n;
  assign frame_start = fp && !fp_d;

  // host decode
  logic [7:0]  memory_page_select;
  logic        mem_sel;
  logic        path_tx;
  logic [1:0]  sub_sel;
  logic [11:0] mem_addr;
  logic        par_ok;
  logic [8:0]  ser_addr;
  assign mem_sel  = addr_lat[TSI_ADDR_MEM_BIT];
  assign path_tx  = memory_page_select[TSI_SEL_PATH_BIT];
  assign sub_sel  = memory_page_select[TSI_SEL_LO +: 2];
  assign mem_addr = {memory_page_select[TSI_PAGE_W-1:0],
                     addr_lat[TSI_ADDR_MEM_BIT-1:0]};
  assign par_ok   = mem_addr < par_chans(prate);
  assign ser_addr = ser_mask(srate, mem_addr);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      memory_page_select <= TSI_PAGE_SELECT_RST;
    end else if (clk_en && host_wr && !mem_sel &&
                 addr_lat[6:0] == TSI_OFS_PAGE_SELECT) begin
      memory_page_select <= ad;
    end
  end

  // block programming sweep of the selected cm high
  tsi_bp_state_t bp_state;
  logic [11:0]   bp_idx;
  logic          bp_tx;
  logic [3:0]    bp_val;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bp_state        <= TSI_BP_IDLE;
      bp_idx          <= 12'h000;
      bp_tx           <= 1'b0;
      bp_val          <= 4'h0;
      block_prog_busy <= 1'b0;
    end else if (clk_en) begin
      unique case (bp_state)
        TSI_BP_IDLE: begin
          if (block_prog_enable && sub_sel == TSI_MS_BLOCK) begin
            bp_state        <= TSI_BP_RUN;
            bp_idx          <= 12'h000;
            bp_tx           <= path_tx;
            bp_val          <= block_prog_data;
            block_prog_busy <= 1'b1;
          end
        end
        TSI_BP_RUN: begin
          // dropping the enable ends the sweep early
          if (!block_prog_enable ||
              bp_idx == 12'(bp_tx ? PAR_DEPTH - 1 : SER_DEPTH - 1)) begin
            bp_state        <= TSI_BP_IDLE;
            block_prog_busy <= 1'b0;
          end else begin
            bp_idx <= bp_idx + 12'h001;
          end
        end
      endcase
    end
  end

  // memory writes: block sweep takes the high memory over host writes
  logic host_mwr;
  assign host_mwr = clk_en && host_wr && mem_sel;
  always_ff @(posedge clk_sys) begin
    if (clk_en && bp_state == TSI_BP_RUN) begin
      if (bp_tx) begin
        tx_cm_high[PW'(bp_idx)] <= {bp_val, 4'h0};
      end else begin
        rx_cm_high[SW'(bp_idx)] <= {bp_val, 3'h0};
      end
    end else if (host_mwr && sub_sel == TSI_MS_CM_HIGH) begin
      if (path_tx && par_ok) begin
        tx_cm_high[PW'(mem_addr)] <= ad;
      end else if (!path_tx) begin
        rx_cm_high[SW'(ser_addr)] <= ad[6:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (host_mwr && sub_sel == TSI_MS_CM_LOW) begin
      if (path_tx && par_ok) begin
        tx_cm_low[PW'(mem_addr)] <= ad;
      end else if (!path_tx) begin
        rx_cm_low[SW'(ser_addr)] <= ad;
      end
    end
  end

  // channel sequencer: frame pulse restarts channel zero
  logic [11:0] chan;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      chan <= 12'h000;
    end else if (clk_en) begin
      // a rate change may leave chan past the new last channel
      if (frame_start || chan >= par_chans(prate) - 12'h001) begin
        chan <= 12'h000;
      end else begin
        chan <= chan + 12'h001;
      end
    end
  end

  // data memories: host writes win, live traffic fills otherwise
  always_ff @(posedge clk_sys) begin
    if (host_mwr && sub_sel == TSI_MS_DATA && !path_tx && par_ok) begin
      rx_data_mem[PW'(mem_addr)] <= ad;
    end else if (clk_en) begin
      rx_data_mem[PW'(chan)] <= rx_par;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (host_mwr && sub_sel == TSI_MS_DATA && path_tx) begin
      tx_data_mem[SW'(ser_addr)] <= ad;
    end else if (clk_en && ser_in_valid) begin
      tx_data_mem[SW'(ser_in_chan)] <= ser_in_data;
    end
  end

  // transmit channel pipeline, stage one fetches connection memory
  logic [7:0] cmh_q;
  logic [7:0] cml_q;
  logic [7:0] byp_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmh_q <= 8'h00;
      cml_q <= 8'h00;
      byp_q <= 8'h00;
    end else if (clk_en) begin
      cmh_q <= tx_cm_high[PW'(chan)];
      cml_q <= tx_cm_low[PW'(chan)];
      byp_q <= rx_par;
    end
  end

  logic [3:0]  src_hi;
  logic [11:0] par_src;
  logic [8:0]  ser_src;
  assign src_hi  = cmh_q[TSI_CMH_SRC_LO +: TSI_SRC_W];
  assign par_src = par_mask(prate, {src_hi, cml_q});
  assign ser_src = ser_mask(srate, {3'h0, src_hi[0], cml_q});

  // stage two: choose channel content and drive pins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      parallel_output_lines <= 8'h00;
      parallel_output_oe    <= 1'b0;
      output_enable_ctl0    <= 1'b0;
      ext_control_pins      <= 3'h0;
    end else if (clk_en) begin
      if (cmh_q[TSI_CMH_MSG]) begin
        parallel_output_lines <= cml_q;
      end else if (cmh_q[TSI_CMH_BYPASS] &&
                   (tmode == TSI_TM1 || tmode == TSI_TM2)) begin
        parallel_output_lines <= byp_q;
      end else if (tmode == TSI_TM4) begin
        parallel_output_lines <= rx_data_mem[PW'(par_src)];
      end else begin
        parallel_output_lines <= tx_data_mem[SW'(ser_src)];
      end
      parallel_output_oe <= cmh_q[TSI_CMH_OE];
      output_enable_ctl0 <= cmh_q[TSI_CMH_OE];
      ext_control_pins   <= (tmode == TSI_TM4) ?
                            {2'b00, cmh_q[TSI_CMH_CTL1]} :
                            cmh_q[TSI_CMH_CTL1 +: 3];
    end
  end

  // 4.096 MHz phase from an accumulator; not jitter free at 200 MHz
  logic [17:0] ph_acc;
  logic        ph_clk;
  logic [8:0]  ph_cnt;
  logic        ph_odd;
  logic [1:0]  fr_cnt;
  logic [TSI_PSW_W-1:0] phase_status_word;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ph_acc            <= 18'h0_0000;
      ph_clk            <= 1'b0;
      ph_cnt            <= 9'h000;
      ph_odd            <= 1'b0;
      fr_cnt            <= 2'h0;
      phase_status_word <= '0;
    end else if (clk_en) begin
      if (ph_acc + TSI_ACC_STEP >= TSI_ACC_WRAP) begin
        ph_acc <= ph_acc + TSI_ACC_STEP - TSI_ACC_WRAP;
        ph_clk <= !ph_clk;
        if (ph_clk) begin
          ph_cnt <= ph_cnt + 9'h001;
        end
      end else begin
        ph_acc <= ph_acc + TSI_ACC_STEP;
      end
      if (frame_start) begin
        ph_cnt <= 9'h000;
        ph_odd <= !ph_odd;
        if (fr_cnt == TSI_FRAMES_PER_SAMPLE - 2'h1) begin
          fr_cnt            <= 2'h0;
          phase_status_word <= {ph_odd, ph_cnt, ph_clk};
        end else begin
          fr_cnt <= fr_cnt + 2'h1;
        end
      end
    end
  end

  // host read data, driven while the read strobe stands
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      host_ad_out <= 8'h00;
      host_ad_oe  <= 1'b0;
    end else if (clk_en) begin
      host_ad_oe  <= host_rd;
      host_ad_out <= 8'h00;
      if (!mem_sel) begin
        unique case (addr_lat[6:0])
          TSI_OFS_PAGE_SELECT: host_ad_out <= memory_page_select;
          TSI_OFS_PHASE_LOW:   host_ad_out <= phase_status_word[7:0];
          TSI_OFS_PHASE_HIGH:  host_ad_out <= {5'h00, TSI_PSW_HIGH_PAD
                                 | phase_status_word[10:8]};
          default:             host_ad_out <= 8'h00;
        endcase
      end else if (path_tx) begin
        unique case (sub_sel)
          TSI_MS_CM_LOW:  host_ad_out <= tx_cm_low[PW'(mem_addr)];
          TSI_MS_CM_HIGH: host_ad_out <= tx_cm_high[PW'(mem_addr)];
          TSI_MS_DATA:    host_ad_out <= tx_data_mem[SW'(ser_addr)];
          TSI_MS_BLOCK:   host_ad_out <= tx_cm_high[PW'(mem_addr)];
        endcase
      end else begin
        unique case (sub_sel)
          TSI_MS_CM_LOW:  host_ad_out <= rx_cm_low[SW'(ser_addr)];
          TSI_MS_CM_HIGH: host_ad_out <= {1'b0, rx_cm_high[SW'(ser_addr)]};
          TSI_MS_DATA:    host_ad_out <= rx_data_mem[PW'(mem_addr)];
          TSI_MS_BLOCK:   host_ad_out <= {1'b0, rx_cm_high[SW'(ser_addr)]};
        endcase
      end
    end
  end
endmodule : tsi_mem_access
`default_nettype wire

/* tsi_pkg_unused_guard.sv */
// no further content
`default_nettype none
`default_nettype wire

/* tsi_host_model.sv */
// host microprocessor model on the multiplexed 8-bit port
// assumes clk_sys from the bench; signals move only after rising edges
`default_nettype none
module tsi_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] host_ad_out,
  input  wire logic       host_ad_oe,
  output logic            host_cs_n,
  output logic            host_ale,
  output logic            host_rd_n,
  output logic            host_wr_n,
  output logic      [7:0] host_ad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drv;
  logic       drv_en;
  // no pull on the bus: a released bus shows the inverted last value
  assign host_ad_in = host_ad_oe ? host_ad_out : (drv_en ? drv : ~drv);
  initial begin
    host_cs_n = 1'b1;
    host_ale = 1'b0;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    drv = 8'h00;
    drv_en = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  // address held two cycles past the latch fall, pins are synchronised
  task automatic addr_phase(input logic [7:0] a);
    host_cs_n <= 1'b0;
    host_ale <= 1'b1;
    drv <= a;
    drv_en <= 1'b1;
    cyc(3);
    host_ale <= 1'b0;
    cyc(2);
  endtask : addr_phase
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_phase(a);
    drv <= d;
    cyc(1);
    host_wr_n <= 1'b0;
    cyc(3);
    host_wr_n <= 1'b1;
    cyc(1);
    host_cs_n <= 1'b1;
    drv_en <= 1'b0;
    cyc(3);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output bit ok);
    addr_phase(a);
    drv_en <= 1'b0;
    host_rd_n <= 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 12 && !ok; i++) begin
      cyc(1);
      ok = host_ad_oe === 1'b1;
    end
    cyc(2);
    d = host_ad_out;
    host_rd_n <= 1'b1;
    host_cs_n <= 1'b1;
    cyc(6);
  endtask : rd
endmodule : tsi_host_model
`default_nettype wire

/* tsi_mem_access_assertions.sv */
// port-level checker for the switch host access block
// assumes binding onto tsi_mem_access; one clock domain
`default_nettype none
module tsi_mem_access_chk
  import tsi_pkg::*;
#(
  parameter int PAR_DEPTH = TSI_PAR_DEPTH,
  parameter int SER_DEPTH = TSI_SER_DEPTH
) (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       clk_en,
  input wire logic       host_cs_n,
  input wire logic       host_ale,
  input wire logic       host_rd_n,
  input wire logic [7:0] host_ad_in,
  input wire logic [7:0] host_ad_out,
  input wire logic       host_ad_oe,
  input wire logic [1:0] timing_mode,
  input wire logic       block_prog_enable,
  input wire logic       block_prog_busy,
  input wire logic       parallel_output_oe,
  input wire logic       output_enable_ctl0,
  input wire logic [2:0] ext_control_pins
);
  logic [7:0]  addr_q;
  logic [12:0] busy_cnt;
  logic        rd_on;
  assign rd_on = !host_rd_n && !host_cs_n;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) addr_q <= 8'h00;
    else if (host_ale) addr_q <= host_ad_in;
  end
  // frozen cycles are not counted, the sweep pauses with them
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) busy_cnt <= 13'h0000;
    else if (!block_prog_busy) busy_cnt <= 13'h0000;
    else if (clk_en) busy_cnt <= busy_cnt + 13'h0001;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_oe_on_read: assert property (rd_on [*5] |-> host_ad_oe)
    else $error("read held but bus not driven");
  a_oe_off_idle: assert property (host_rd_n [*5] |-> !host_ad_oe)
    else $error("bus driven without read");
  // unwritten connection memory leaves both pins unknown but equal
  a_ctl0_is_oe: assert property (
    output_enable_ctl0 === parallel_output_oe)
    else $error("control pin 0 differs from output enable");
  a_tm4_ctl_off: assert property ((timing_mode == 2'h3) [*4]
    |-> ext_control_pins[2:1] == 2'h0)
    else $error("control pins 2 or 3 active in mode four");
  a_sweep_length: assert property ($fell(block_prog_busy)
    && $past(block_prog_enable) && block_prog_enable
    |-> busy_cnt == 13'(PAR_DEPTH) || busy_cnt == 13'(SER_DEPTH))
    else $error("block sweep length wrong");
  a_sweep_abort: assert property (block_prog_busy && !block_prog_enable
    |-> ##[1:3] !block_prog_busy)
    else $error("block sweep not stopped");
  a_busy_needs_en: assert property ($rose(block_prog_busy)
    |-> $past(block_prog_enable))
    else $error("block sweep started without enable");
  a_unmapped_zero: assert property ((rd_on && !addr_q[7]
    && addr_q[6:0] > 7'h09) [*5] |-> host_ad_out == 8'h00)
    else $error("unmapped register read not zero");
  a_psw_pad: assert property ((rd_on && addr_q == 8'h09) [*5]
    |-> host_ad_out[7:3] == 5'h00)
    else $error("phase high byte upper bits not zero");
endmodule : tsi_mem_access_chk
bind tsi_mem_access tsi_mem_access_chk #(
  .PAR_DEPTH(PAR_DEPTH),
  .SER_DEPTH(SER_DEPTH)
) i_chk (
  .clk_sys(clk_sys),
  .reset(reset),
  .clk_en(clk_en),
  .host_cs_n(host_cs_n),
  .host_ale(host_ale),
  .host_rd_n(host_rd_n),
  .host_ad_in(host_ad_in),
  .host_ad_out(host_ad_out),
  .host_ad_oe(host_ad_oe),
  .timing_mode(timing_mode),
  .block_prog_enable(block_prog_enable),
  .block_prog_busy(block_prog_busy),
  .parallel_output_oe(parallel_output_oe),
  .output_enable_ctl0(output_enable_ctl0),
  .ext_control_pins(ext_control_pins)
);
`default_nettype wire

/* tsi_mem_access_tb.sv */
// self-checking bench for the switch host access block
// assumes host model and checker compiled before it
`default_nettype none
module tsi_mem_access_tb
  import tsi_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } tsi_row_t;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] srate;
    logic [7:0] hi;
    logic [7:0] lines;
    logic       oe;
    logic [2:0] ctl;
  } tsi_case_t;
  localparam logic [7:0] PG = {1'b0, TSI_OFS_PAGE_SELECT};
  localparam logic [7:0] PH_LO = {1'b0, TSI_OFS_PHASE_LOW};
  localparam logic [7:0] PH_HI = {1'b0, TSI_OFS_PHASE_HIGH};
  localparam tsi_row_t ROWS [8] = '{
    '{8'h00, PG, 8'h5A, 8'h5A}, '{8'h80, 8'h85, 8'h3C, 8'h3C},
    '{8'hA0, 8'hFF, 8'hC3, 8'hC3}, '{8'h92, 8'hFD, 8'h11, 8'h11},
    '{8'h00, 8'h80, 8'h77, 8'h77}, '{8'hC0, 8'h81, 8'h99, 8'h99},
    '{8'h80, 8'h20, 8'hFF, 8'h00}, '{8'h81, 8'h85, 8'h66, 8'h66}};
  localparam tsi_case_t CASES [9] = '{
    '{2'h0, 2'h0, 8'h2D, 8'hA5, 1'b1, 3'h5},
    '{2'h3, 2'h0, 8'h2D, 8'hA5, 1'b1, 3'h1},
    '{2'h0, 2'h0, 8'h2C, 8'hA5, 1'b0, 3'h5},
    '{2'h0, 2'h0, 8'h03, 8'h6E, 1'b1, 3'h0},
    '{2'h1, 2'h0, 8'h07, 8'hA5, 1'b1, 3'h0},
    '{2'h2, 2'h0, 8'h03, 8'h42, 1'b1, 3'h0},
    '{2'h0, 2'h1, 8'h11, 8'h24, 1'b1, 3'h2},
    '{2'h0, 2'h0, 8'h11, 8'h42, 1'b1, 3'h2},
    '{2'h0, 2'h3, 8'h11, 8'h24, 1'b1, 3'h2}};
  logic       clk_sys = 1'b0;
  logic       reset, clk_en, block_prog_enable, block_prog_busy;
  logic       host_cs_n, host_ale, host_rd_n, host_wr_n, host_ad_oe;
  logic       rx_parallel_frame_pulse, ser_in_valid, parallel_output_oe;
  logic       output_enable_ctl0;
  logic [1:0] timing_mode, serial_rate, parallel_rate;
  logic [2:0] ext_control_pins;
  logic [3:0] block_prog_data;
  logic [7:0] host_ad_in, host_ad_out, rx_parallel_lines, ser_in_data;
  logic [7:0] parallel_output_lines, rd_q, rd_q2;
  logic [8:0] ser_in_chan;
  int         err_total, n_checks, hits, cnt;
  tsi_mem_access i_dut (.*);
  tsi_host_model i_host (.*);
  always #2.5 clk_sys = ~clk_sys;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, output logic [7:0] d);
    bit ok;
    i_host.rd(a, d, ok);
    chk("read answer", 16'h0001, {15'h0000, ok});
    if (!ok) summarize();
  endtask : rdc
  task automatic wait_busy(input logic lvl, input int lim, output int n);
    n = 0;
    while (block_prog_busy !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
    chk("busy wait", 16'h0001, {15'h0000, block_prog_busy === lvl});
    if (block_prog_busy !== lvl) summarize();
  endtask : wait_busy
  task automatic frame_pulse;
    rx_parallel_frame_pulse <= 1'b1;
    cyc(3);
    rx_parallel_frame_pulse <= 1'b0;
  endtask : frame_pulse
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // a hang counts as a mismatch and still reaches the report
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_total++;
    summarize();
  end
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    timing_mode = 2'h0;
    serial_rate = 2'h1;
    parallel_rate = 2'h0;
    block_prog_enable = 1'b0;
    block_prog_data = 4'h0;
    rx_parallel_frame_pulse = 1'b0;
    rx_parallel_lines = 8'h6E;
    ser_in_valid = 1'b0;
    ser_in_chan = 9'h000;
    ser_in_data = 8'h00;
    cyc(16);
    reset <= 1'b0;
    cyc(4);
    // written at add/drop rate so both sources stay apart
    ser_in_valid <= 1'b1;
    ser_in_chan <= 9'h0A5;
    ser_in_data <= 8'h42;
    cyc(1);
    ser_in_chan <= 9'h1A5;
    ser_in_data <= 8'h24;
    cyc(1);
    ser_in_valid <= 1'b0;
    foreach (ROWS[i]) begin
      i_host.wr(PG, ROWS[i].page);
      i_host.wr(ROWS[i].addr, ROWS[i].wdata);
      rdc(ROWS[i].addr, rd_q);
      chk("row read", {8'h00, ROWS[i].exp}, {8'h00, rd_q});
    end
    repeat (4) begin
      frame_pulse();
      cyc(60);
    end
    rdc(PH_HI, rd_q);
    rdc(PH_HI, rd_q2);
    chk("phase high pad", 16'h0000, {11'h000, rd_q[7:3]});
    chk("phase high twice", {8'h00, rd_q}, {8'h00, rd_q2});
    // two more frames: next capture sees the same frame parity
    repeat (2) begin
      frame_pulse();
      cyc(60);
    end
    rdc(PH_HI, rd_q2);
    chk("phase parity", {15'h0000, rd_q[2]}, {15'h0000, rd_q2[2]});
    rdc(PH_LO, rd_q);
    rdc(PH_LO, rd_q2);
    chk("phase low twice", {8'h00, rd_q}, {8'h00, rd_q2});
    i_host.wr(PG, 8'h80);
    i_host.wr(8'h80, 8'hA5);
    i_host.wr(PG, 8'hA0);
    foreach (CASES[i]) begin
      timing_mode <= CASES[i].mode;
      serial_rate <= CASES[i].srate;
      i_host.wr(8'h80, CASES[i].hi);
      hits = 0;
      repeat (2) begin
        frame_pulse();
        repeat (30) begin
          cyc(1);
          if (parallel_output_oe === CASES[i].oe
              && output_enable_ctl0 === CASES[i].oe
              && ext_control_pins === CASES[i].ctl
              && (!CASES[i].oe || parallel_output_lines === CASES[i].lines))
            hits++;
        end
      end
      chk("channel hits", 16'h0002, 16'(hits));
    end
    timing_mode <= 2'h0;
    i_host.wr(PG, 8'hE0);
    block_prog_data <= 4'hB;
    block_prog_enable <= 1'b1;
    wait_busy(1'b1, 8, cnt);
    wait_busy(1'b0, 3000, cnt);
    chk("sweep cycles", 16'(TSI_PAR_DEPTH), 16'(cnt));
    // a level enable restarts the sweep; dropping it aborts that rerun
    block_prog_enable <= 1'b0;
    cyc(2);
    wait_busy(1'b0, 8, cnt);
    i_host.wr(PG, 8'hA0);
    rdc(8'h80, rd_q);
    chk("block first", 16'h00B0, {8'h00, rd_q});
    i_host.wr(PG, 8'hB2);
    rdc(8'hFD, rd_q);
    chk("block last", 16'h00B0, {8'h00, rd_q});
    reset <= 1'b1;
    cyc(3);
    reset <= 1'b0;
    cyc(4);
    rdc(PG, rd_q);
    chk("page after reset", {8'h00, TSI_PAGE_SELECT_RST}, {8'h00, rd_q});
    summarize();
  end
endmodule : tsi_mem_access_tb
`default_nettype wire
